/* eqf_pkg.sv */
// Operation
// RL1 - Samples may pass through programmable FIR equalizer
// RL2 - Mode field, share and merge bits select mode
// RL3 - Dual mode filters each channel with own coefficients
// RL4 - Single mode applies one nine-tap filter
// RL5 - Center tap is 18 bits, LSB two^-16
// RL6 - Other taps 12 bits, LSB two^-10..-16
// RL7 - One common LSB weight for non-center taps
// RL8 - Time-varying mode keeps two nine-tap sets
// RL9 - Coefficients come from writable banks A and B
// RL10 - Time-varying mode alternates sets every sample
// RL11 - Disabled filter passes samples unchanged, keeps coefficients
// RL12 - Full-precision accumulate, round only the output
`default_nettype none
package eqf_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses)
   localparam logic [11:0] EQF_CTRL_OFF   = 12'h000;
   localparam logic [11:0] EQF_STATUS_OFF = 12'h004;
   localparam logic [11:0] EQF_COEF_A_OFF = 12'h040;
   localparam logic [11:0] EQF_COEF_B_OFF = 12'h080;

   // Control register fields
   localparam int EQF_MODE_LSB   = 0;
   localparam int EQF_SHARE_BIT  = 4;
   localparam int EQF_MERGE_BIT  = 5;
   localparam int EQF_LINK_BIT   = 8;
   localparam int EQF_SHIFT_A_LSB = 16;
   localparam int EQF_SHIFT_B_LSB = 20;

   // Status register fields
   localparam int EQF_ST_MODE_LSB  = 0;
   localparam int EQF_ST_LEVEL_LSB = 8;
   localparam int EQF_ST_PHASE_BIT = 16;

   // Mode field values
   localparam logic [1:0] EQF_MODE_OFF = 2'h0;
   localparam logic [1:0] EQF_MODE_ON  = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // Filter geometry and number formats
   localparam int EQF_TAPS       = 9;
   localparam int EQF_CENTER     = 4;
   localparam int EQF_CENTER_W   = 18;
   localparam int EQF_NONCTR_W   = 12;
   localparam int EQF_FRAC_W     = 16;
   localparam logic [2:0] EQF_MAX_SHIFT = 3'h6;
   localparam logic [15:0] EQF_ROUND_HALF = 16'h8000;

   // Reset values: unity center tap, all other taps zero
   localparam logic [17:0] EQF_CENTER_RST = 18'h10000;
   localparam logic [17:0] EQF_NONCTR_RST = 18'h00000;
   localparam logic [2:0]  EQF_SHIFT_RST  = 3'h0;

   // Free-slot margin for the input ready (pipeline depth in flight)
   localparam int EQF_FIFO_MARGIN = 4;

   // Effective filter mode, Gray coded
   typedef enum logic [1:0]
   {
      EQF_BYPASS = 2'b00,
      EQF_DUAL   = 2'b01,
      EQF_TV     = 2'b11,
      EQF_SINGLE = 2'b10
   } eqf_mode_t;

endpackage
`default_nettype wire

/* eqf_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries filter results into the output FIFO and drained words out of it
interface eqf_fifo_if #(parameter int W = 24, parameter int D = 16);
   logic                 in_valid;
   logic                 in_ready;
   logic [W-1:0]         in_data;
   logic                 out_valid;
   logic                 out_ready;
   logic [W-1:0]         out_data;
   logic [$clog2(D):0]   level;

   modport store
   (
      input  in_valid, in_data, out_ready,
      output in_ready, out_valid, out_data, level
   );

   modport user
   (
      output in_valid, in_data, out_ready,
      input  in_ready, out_valid, out_data, level
   );
endinterface
`default_nettype wire

/* eqf_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
// Flop-based FIFO with a registered output word
module eqf_fifo #(parameter int W = 24, parameter int D = 16)
(
   // Clock and reset
   input wire logic     pclk,
   input wire logic     presetn,
   // Both sides of the buffer
   eqf_fifo_if.store    port
);
   localparam int AW = $clog2(D);

   typedef struct packed
   {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [AW:0]         cnt;
      logic                ov;
      logic [W-1:0]        od;
   } eqf_fifo_st_t;

   eqf_fifo_st_t q, d;
   logic push;
   logic load;

   // Pointer advance with wrap for any depth
   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == AW'(D - 1)) ? '0 : p + AW'(1);
   endfunction

   // Honest full/empty from the stored count; level includes the output word
   assign port.in_ready  = (q.cnt != (AW+1)'(D));
   assign port.out_valid = q.ov;
   assign port.out_data  = q.od;
   assign port.level     = q.cnt + (AW+1)'(q.ov);

   // Next state
   always_comb
   begin
      d    = q;
      push = port.in_valid && (q.cnt != (AW+1)'(D));
      load = (q.cnt != '0) && (!q.ov || port.out_ready);
      if (push)
      begin
         d.mem[q.wr] = port.in_data;
         d.wr        = nxt(q.wr);
      end
      if (load)
      begin
         d.od = q.mem[q.rd];
         d.ov = 1'b1;
         d.rd = nxt(q.rd);
      end
      else if (port.out_ready)
      begin
         d.ov = 1'b0;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '0;
      else
         q <= d;
   end
endmodule
`default_nettype wire

/* eqf_filter.sv */
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Programmable nine-tap equalization filter with APB registers
module eqf_filter #(parameter int SAMPLE_W = 12, parameter int FIFO_DEPTH = 16)
(
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic [11:0]            paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Converter samples in (lane A, lane B)
   input  wire logic                   s_valid,
   output logic                        s_ready,
   input  wire logic [SAMPLE_W-1:0]    s_data_a,
   input  wire logic [SAMPLE_W-1:0]    s_data_b,
   // Filtered samples out
   output logic                        m_valid,
   input  wire logic                   m_ready,
   output logic [SAMPLE_W-1:0]         m_data_a,
   output logic [SAMPLE_W-1:0]         m_data_b
);
   import eqf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Local widths and types
   localparam int ACC_W = SAMPLE_W + EQF_CENTER_W + 4;
   localparam int LW    = $clog2(FIFO_DEPTH) + 1;
   localparam logic signed [ACC_W-1:0] SMAX = ACC_W'((64'sd1 <<< (SAMPLE_W - 1)) - 64'sd1);
   localparam logic signed [ACC_W-1:0] SMIN = ACC_W'(-(64'sd1 <<< (SAMPLE_W - 1)));

   typedef logic [EQF_TAPS-1:0][EQF_CENTER_W-1:0] eqf_bank_t;
   typedef logic [EQF_TAPS-1:0][SAMPLE_W-1:0]     eqf_line_t;

   typedef struct packed
   {
      logic [1:0]          mode_sel;     // filter_mode_select
      logic                share;        // coefficient_share_bit
      logic                merge;        // channel_merge_bit
      logic                link_single;  // link_mode_select
      logic [2:0]          shift_a;
      logic [2:0]          shift_b;
      eqf_bank_t           coef_a;       // channel_a_coefficients
      eqf_bank_t           coef_b;       // channel_b_coefficients
      eqf_line_t           line_a;
      eqf_line_t           line_b;
      logic                phase;
      logic                res_v;
      logic [SAMPLE_W-1:0] res_a;
      logic [SAMPLE_W-1:0] res_b;
      logic                s_rdy;
      logic                apb_rdy;
      logic                apb_err;
      logic [31:0]         apb_rd;
   } eqf_state_t;

   eqf_state_t q, d;
   eqf_mode_t  mode;

   eqf_fifo_if #(.W(2 * SAMPLE_W), .D(FIFO_DEPTH)) fq ();

   ////////////////////////////////////////////////////////////////////////////////
   // Functions

   // Coefficient word index of an address inside a bank, or 4'hf when outside
   function automatic logic [3:0] coef_idx(input logic [11:0] a, input logic [11:0] base);
      logic [11:0] off;
      off = a - base;
      if (a >= base && off[11:2] < 10'(EQF_TAPS) && off[1:0] == 2'h0)
         coef_idx = off[5:2];
      else
         coef_idx = 4'hf;
   endfunction

   // Byte-lane merge of a write into a register image
   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (st[i])
            r[8*i +: 8] = wd[8*i +: 8];
      strb_merge = r;
   endfunction

   // Clamp of the non-center LSB weight selector to the seven legal steps
   function automatic logic [2:0] clamp_shift(input logic [2:0] s);
      clamp_shift = (s > EQF_MAX_SHIFT) ? EQF_MAX_SHIFT : s;
   endfunction

   // Nine-tap dot product, every tap aligned to the two^-16 grid
   function automatic logic signed [ACC_W-1:0] fir(input eqf_line_t x, input eqf_bank_t c,
                                                   input logic [2:0] sh);
      logic signed [ACC_W-1:0] acc;
      logic signed [ACC_W-1:0] xs;
      logic signed [ACC_W-1:0] cs;
      logic signed [ACC_W-1:0] p;
      acc = '0;
      for (int k = 0; k < EQF_TAPS; k++)
      begin
         xs = ACC_W'($signed(x[k]));
         if (k == EQF_CENTER)
         begin
            cs = ACC_W'($signed(c[k]));                               // RL5
            p  = xs * cs;
         end
         else
         begin
            cs = ACC_W'($signed(c[k][EQF_NONCTR_W-1:0]));              // RL6
            p  = (xs * cs) <<< (EQF_MAX_SHIFT - clamp_shift(sh));      // RL7
         end
         acc = acc + p;                                                // RL12
      end
      fir = acc;
   endfunction

   // Convergent rounding of the accumulator and saturation to the sample width
   function automatic logic [SAMPLE_W-1:0] rnd_sat(input logic signed [ACC_W-1:0] acc);
      logic signed [ACC_W-1:0] r;
      logic [EQF_FRAC_W-1:0]   fr;
      r  = acc >>> EQF_FRAC_W;
      fr = acc[EQF_FRAC_W-1:0];
      if (fr > EQF_ROUND_HALF || (fr == EQF_ROUND_HALF && r[0]))
         r = r + ACC_W'(1);                                            // RL12
      if (r > SMAX)
         r = SMAX;
      else if (r < SMIN)
         r = SMIN;
      rnd_sat = r[SAMPLE_W-1:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Mode decode from the mode field, steering bits and link mode
   always_comb
   begin
      mode = EQF_BYPASS;
      if (q.mode_sel == EQF_MODE_ON)                                   // RL2
      begin
         case ({q.share, q.merge})
            2'b00:   mode = q.link_single ? EQF_BYPASS : EQF_DUAL;     // RL3
            2'b11:   mode = q.link_single ? EQF_SINGLE : EQF_BYPASS;   // RL4
            2'b01:   mode = EQF_TV;                                    // RL8
            default: mode = EQF_BYPASS;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // FIFO connections
   assign fq.in_valid  = q.res_v;
   assign fq.in_data   = {q.res_b, q.res_a};
   assign fq.out_ready = m_ready;

   eqf_fifo #(.W(2 * SAMPLE_W), .D(FIFO_DEPTH)) u_fifo
   (
      .pclk    (pclk),
      .presetn (presetn),
      .port    (fq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic: registers, delay lines, datapath
   always_comb
   begin
      logic [3:0]  ia;
      logic [3:0]  ib;
      logic        hit;
      logic [31:0] rv;
      logic [31:0] ctrl;
      logic [31:0] nw;
      logic        take;

      d    = q;
      ia   = coef_idx(paddr, EQF_COEF_A_OFF);
      ib   = coef_idx(paddr, EQF_COEF_B_OFF);
      hit  = 1'b0;
      take = s_valid && q.s_rdy;
      rv   = '0;
      nw   = '0;
      ctrl = '0;
      ctrl[EQF_MODE_LSB +: 2]    = q.mode_sel;
      ctrl[EQF_SHARE_BIT]        = q.share;
      ctrl[EQF_MERGE_BIT]        = q.merge;
      ctrl[EQF_LINK_BIT]         = q.link_single;
      ctrl[EQF_SHIFT_A_LSB +: 3] = q.shift_a;
      ctrl[EQF_SHIFT_B_LSB +: 3] = q.shift_b;

      // Read mux and address decode
      if (paddr == EQF_CTRL_OFF)
      begin
         hit = 1'b1;
         rv  = ctrl;
      end
      else if (paddr == EQF_STATUS_OFF)
      begin
         hit = 1'b1;
         rv[EQF_ST_MODE_LSB +: 2]   = mode;
         rv[EQF_ST_LEVEL_LSB +: LW] = fq.level;
         rv[EQF_ST_PHASE_BIT]       = q.phase;
      end
      else if (ia != 4'hf)
      begin
         hit = 1'b1;
         rv  = 32'(q.coef_a[ia]);
      end
      else if (ib != 4'hf)
      begin
         hit = 1'b1;
         rv  = 32'(q.coef_b[ib]);
      end

      // APB answer: ready in the first access cycle, zero wait states
      d.apb_rdy = psel && !penable && !q.apb_rdy;
      d.apb_err = 1'b0;
      if (psel && !penable && !q.apb_rdy)
      begin
         d.apb_err = !hit;
         d.apb_rd  = (!pwrite && hit) ? rv : 32'h00000000;
      end

      // Register writes take effect at the completing access edge
      if (psel && penable && q.apb_rdy && pwrite && hit)
      begin
         if (paddr == EQF_CTRL_OFF)
         begin
            nw            = strb_merge(ctrl, pwdata, pstrb);
            d.mode_sel    = nw[EQF_MODE_LSB +: 2];
            d.share       = nw[EQF_SHARE_BIT];
            d.merge       = nw[EQF_MERGE_BIT];
            d.link_single = nw[EQF_LINK_BIT];
            d.shift_a     = nw[EQF_SHIFT_A_LSB +: 3];
            d.shift_b     = nw[EQF_SHIFT_B_LSB +: 3];
         end
         else if (ia != 4'hf)
         begin
            nw = strb_merge(32'(q.coef_a[ia]), pwdata, pstrb);
            d.coef_a[ia] = (ia == 4'(EQF_CENTER)) ? nw[EQF_CENTER_W-1:0]
                           : {6'h00, nw[EQF_NONCTR_W-1:0]};          // RL9
         end
         else if (ib != 4'hf)
         begin
            nw = strb_merge(32'(q.coef_b[ib]), pwdata, pstrb);
            d.coef_b[ib] = (ib == 4'(EQF_CENTER)) ? nw[EQF_CENTER_W-1:0]
                           : {6'h00, nw[EQF_NONCTR_W-1:0]};          // RL9
         end
      end

      // Sample acceptance: shift both delay lines, compute one result word
      d.res_v = take;
      if (take)
      begin
         d.line_a = {q.line_a[EQF_TAPS-2:0], s_data_a};
         d.line_b = {q.line_b[EQF_TAPS-2:0], s_data_b};
         case (mode)
            EQF_DUAL:
            begin
               d.res_a = rnd_sat(fir(d.line_a, q.coef_a, q.shift_a));  // RL3
               d.res_b = rnd_sat(fir(d.line_b, q.coef_b, q.shift_b));  // RL3
            end
            EQF_SINGLE:
            begin
               d.res_a = rnd_sat(fir(d.line_a, q.coef_a, q.shift_a));  // RL4
               d.res_b = '0;
            end
            EQF_TV:
            begin
               d.res_a = q.phase ? rnd_sat(fir(d.line_a, q.coef_b, q.shift_b))
                                 : rnd_sat(fir(d.line_a, q.coef_a, q.shift_a)); // RL8
               d.res_b = '0;
               d.phase = !q.phase;                                     // RL10
            end
            EQF_BYPASS:
            begin
               d.res_a = s_data_a;                                     // RL11
               d.res_b = s_data_b;                                     // RL11
            end
            default:
            begin
               d.res_a = s_data_a;
               d.res_b = s_data_b;
            end
         endcase
         if (mode != EQF_TV)
            d.phase = 1'b0;
      end

      // Input ready leaves room for the words already in flight      // RL1
      d.s_rdy = fq.in_ready && (fq.level <= LW'(FIFO_DEPTH - EQF_FIFO_MARGIN));
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '0;
         for (int k = 0; k < EQF_TAPS; k++)
         begin
            q.coef_a[k] <= (k == EQF_CENTER) ? EQF_CENTER_RST : EQF_NONCTR_RST;
            q.coef_b[k] <= (k == EQF_CENTER) ? EQF_CENTER_RST : EQF_NONCTR_RST;
         end
         q.shift_a <= EQF_SHIFT_RST;
         q.shift_b <= EQF_SHIFT_RST;
      end
      else
      begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops
   assign prdata   = q.apb_rd;
   assign pready   = q.apb_rdy;
   assign pslverr  = q.apb_err;
   assign s_ready  = q.s_rdy;
   assign m_valid  = fq.out_valid;
   assign m_data_a = fq.out_data[SAMPLE_W-1:0];
   assign m_data_b = fq.out_data[2*SAMPLE_W-1:SAMPLE_W];
endmodule
`default_nettype wire

/* eqf_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level bus, stream and latency checks for the filter
module eqf_checker #(parameter int SAMPLE_W = 12)
(
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // Register bus
   input wire logic                psel,
   input wire logic                penable,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   // Sample stream
   input wire logic                s_valid,
   input wire logic                s_ready,
   input wire logic                m_valid,
   input wire logic                m_ready,
   input wire logic [SAMPLE_W-1:0] m_data_a,
   input wire logic [SAMPLE_W-1:0] m_data_b
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////////
   // Three quiet input cycles, then a take into an empty pipeline
   sequence quiet3;
      (!(s_valid && s_ready)) [*3];
   endsequence
   sequence empty_take;
      quiet3 ##1 (s_valid && s_ready && !m_valid);
   endsequence

   ////////////////////////////////////////////////////////////////////////////////
   setup_answer_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("answer longer than one cycle");
   bus_idle_a: assert property (!psel |=> !pready)
      else $error("answer without request");
   err_qual_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error flag without answer or with data");
   out_hold_a: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data_a) && $stable(m_data_b))
      else $error("output word changed before acceptance");
   take_latency_a: assert property (empty_take |-> ##1 !m_valid ##1 !m_valid ##1 m_valid)
      else $error("result not three cycles after take");
   drain_quiet_a: assert property (quiet3 ##0 !m_valid |=> !m_valid)
      else $error("output without input");
   flow_free_a: assert property (m_ready [*8] |-> s_ready)
      else $error("input refused while output drains");
endmodule

bind eqf_filter eqf_checker #(.SAMPLE_W(SAMPLE_W)) u_chk
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .s_valid(s_valid), .s_ready(s_ready), .m_valid(m_valid), .m_ready(m_ready),
   .m_data_a(m_data_a), .m_data_b(m_data_b)
);
`default_nettype wire

/* eqf_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Converter sample source and downstream sink around the filter
module eqf_conv_model #(parameter int W = 12)
(
   // Clock and reset
   input wire logic         pclk,
   input wire logic         presetn,
   // Source side
   output logic             s_valid,
   input wire logic         s_ready,
   output logic [W-1:0]     s_data_a,
   output logic [W-1:0]     s_data_b,
   // Sink side
   input wire logic         m_valid,
   output logic             m_ready,
   input wire logic [W-1:0] m_data_a,
   input wire logic [W-1:0] m_data_b
);
   logic [2*W-1:0] src_q[$];
   logic [2*W-1:0] sink_q[$];
   logic           stall = 1'b0;
   logic           slow = 1'b0;
   logic           tick_q;

   // Source holds a word until taken; idle lines toggle so stale data never passes
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_valid <= 1'b0;
         s_data_a <= '0;
         s_data_b <= '0;
         m_ready <= 1'b0;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= ~tick_q;
         m_ready <= !stall && (!slow || tick_q);
         if (m_valid && m_ready)
            sink_q.push_back({m_data_b, m_data_a});
         if (!s_valid || s_ready)
         begin
            s_valid <= (src_q.size() > 0);
            if (src_q.size() > 0)
               {s_data_b, s_data_a} <= src_q.pop_front();
            else
               {s_data_b, s_data_a} <= ~{s_data_b, s_data_a};
         end
      end
   end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the equalization filter
module tb_top;
   import eqf_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr, s_data_a, s_data_b, m_data_a, m_data_b;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic        s_valid, s_ready, m_valid, m_ready;
   int          bad_count = 0, checks = 0, sha = 0, shb = 7, ph = 0, idx = 0;
   int          ca[9], cb[9], ha[9], hb[9];
   logic [23:0] exp_q[$];
   // Control word and expected effective mode
   logic [13:0] tbl[10] = '{14'h0030, 14'h1002, 14'h2132, 14'h3022, 14'h3122,
                            14'h0102, 14'h0032, 14'h0012, 14'h0003, 14'h0001};

   eqf_filter #(.SAMPLE_W(12), .FIFO_DEPTH(16)) DUT
   (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .s_valid(s_valid), .s_ready(s_ready),
      .s_data_a(s_data_a), .s_data_b(s_data_b), .m_valid(m_valid), .m_ready(m_ready),
      .m_data_a(m_data_a), .m_data_b(m_data_b)
   );
   eqf_conv_model #(.W(12)) u_mod
   (
      .pclk(pclk), .presetn(presetn), .s_valid(s_valid), .s_ready(s_ready),
      .s_data_a(s_data_a), .s_data_b(s_data_b), .m_valid(m_valid),
      .m_ready(m_ready), .m_data_a(m_data_a), .m_data_b(m_data_b)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Verdict and end of run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         bad_count++;
         report_and_stop;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle cycle so the next call never re-drives psel in this time step
      @(posedge pclk);
   endtask

   // Filter reference: full-precision sum, round half to even, saturate
   function automatic logic [11:0] fir(input int h[9], input int c[9], input int sh);
      longint s, q, r;
      s = 0;
      if (sh > 6)
         sh = 6;
      for (int k = 0; k < 9; k++)
         s += (k == 4) ? longint'(c[k]) * h[k] : (longint'(c[k]) * h[k]) <<< (6 - sh);
      q = s >>> 16;
      r = s & 64'hffff;
      if (r > 32768 || (r == 32768 && q[0]))
         q++;
      q = (q > 2047) ? 2047 : (q < -2048) ? -2048 : q;
      return q[11:0];
   endfunction

   // Send n samples in one mode, optionally filling the buffer first
   task automatic run(input int m, input logic [31:0] ctrl, input int n, input bit st);
      int w;
      logic [11:0] fa;
      apb(1'b1, EQF_CTRL_OFF, ctrl);
      ph = 0;
      if (st)
         u_mod.stall <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         idx++;
         for (int k = 8; k > 0; k--)
         begin
            ha[k] = ha[k-1];
            hb[k] = hb[k-1];
         end
         ha[0] = (idx * 613 + 100) % 4096 - 2048;
         hb[0] = (idx * 1229 + 7) % 4096 - 2048;
         fa = (m == 3 && ph == 1) ? fir(ha, cb, shb) : fir(ha, ca, sha);
         exp_q.push_back(m == 0 ? {hb[0][11:0], ha[0][11:0]} :
                         m == 1 ? {fir(hb, cb, shb), fa} : {12'h0, fa});
         ph = (m == 3) ? 1 - ph : ph;
         u_mod.src_q.push_back({hb[0][11:0], ha[0][11:0]});
      end
      w = 0;
      while (st && s_ready !== 1'b0 && w < 200)
      begin
         @(posedge pclk);
         w++;
      end
      if (st)
      begin
         chk({31'h0, s_ready}, 32'h0);
         u_mod.stall <= 1'b0;
         u_mod.slow <= 1'b1;
      end
      while (u_mod.sink_q.size() < n && w < 3000)
      begin
         @(posedge pclk);
         w++;
      end
      if (w >= 3000)
      begin
         bad_count++;
         report_and_stop;
      end
      while (exp_q.size() > 0)
         chk({8'h0, u_mod.sink_q.pop_front()}, {8'h0, exp_q.pop_front()});
      $display("test mode %0d done", m);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, EQF_CTRL_OFF, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, EQF_COEF_A_OFF + 12'h010, 32'h0);
      chk(rd, {14'h0, EQF_CENTER_RST});
      apb(1'b0, EQF_COEF_B_OFF, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'hffc, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("test registers done");
      for (int i = 0; i < 10; i++)
      begin
         apb(1'b1, EQF_CTRL_OFF, {20'h0, tbl[i][11:0]});
         apb(1'b0, EQF_STATUS_OFF, 32'h0);
         chk({30'h0, rd[1:0]}, {30'h0, tbl[i][13:12]});
      end
      $display("test mode decode done");
      for (int k = 0; k < 9; k++)
      begin
         ca[k] = (k == 4) ? 98304 : k * 100 - 400;
         cb[k] = (k == 4) ? 32768 : (k % 2) ? 2047 : -2048;
         apb(1'b1, EQF_COEF_A_OFF + 12'(4 * k), ca[k] & ((k == 4) ? 32'h3ffff : 32'hfff));
         apb(1'b1, EQF_COEF_B_OFF + 12'(4 * k), cb[k] & ((k == 4) ? 32'h3ffff : 32'hfff));
      end
      // Byte-lane write touches only lane 1 of tap 0, then tap 0 is restored
      pstrb <= 4'h2;
      apb(1'b1, EQF_COEF_A_OFF, 32'hffffffff);
      pstrb <= 4'hf;
      apb(1'b0, EQF_COEF_A_OFF, 32'h0);
      chk(rd, (ca[0] & 32'h0ff) | 32'hf00);
      apb(1'b1, EQF_COEF_A_OFF, ca[0] & 32'hfff);
      apb(1'b0, EQF_COEF_A_OFF, 32'h0);
      chk(rd, ca[0] & 32'hfff);
      run(0, 32'h0070_0000, 20, 1'b0);
      run(1, 32'h0070_0002, 30, 1'b0);
      run(2, 32'h0070_0132, 30, 1'b0);
      run(3, 32'h0070_0022, 40, 1'b1);
      report_and_stop;
   end
endmodule
`default_nettype wire
